//--- rtl/vfd_fetch_dispatch.sv
// Fetch packet buffer, execute packet splitter and unit dispatcher.
`timescale 1ns/1ns
`include "vfd_params.svh"
module vfd_fetch_dispatch
    import vfd_pkg::*;
#(
    parameter logic [31:0] RESET_ADDR = `VFD_RESET_ADDR
) (
    input  wire logic         CLK,
    input  wire logic         ARST_N,
    output logic              FETCH_REQ,
    output logic [31:0]       FETCH_ADDR,
    input  wire logic         FETCH_VALID,
    input  wire logic [255:0] FETCH_DATA,
    output logic [7:0]        UNIT_VALID,
    output logic [255:0]      UNIT_INSTR,
    output logic              EP_VALID,
    output logic [3:0]        EP_SIZE,
    output logic              DISP_STALL
);
    localparam int NW  = `VFD_WORDS;
    localparam int WIN = `VFD_WIN;

    vfd_word_t   win_r [WIN];
    vfd_word_t   win_nxt [WIN];
    vfd_cnt_t    cnt_r;
    vfd_cnt_t    cnt_nxt;
    logic        pend_r;
    logic [31:0] pc_r;
    logic [63:0] wmask_r;
    logic [63:0] wmask_nxt;
    logic [7:0]  term;
    logic [7:0]  in_ep;
    logic [7:0]  xrd;
    logic [2:0]  uidx [NW];
    logic        complete;
    logic        hazard;
    logic        disp_fire;
    logic        load;
    vfd_len_t    len;
    vfd_cnt_t    pop;
    vfd_cnt_t    base;
    logic [7:0]  unit_v_nxt;
    vfd_word_t   unit_i_nxt [NW];
    vfd_word_t   unit_i_r [NW];

    function automatic vfd_len_t first_term(input logic [7:0] t);
        vfd_len_t l;
        l = 4'h0;
        for (int i = NW - 1; i >= 0; i--) begin
            if (t[i]) begin
                l = 4'(i + 1);
            end
        end
        return l;
    endfunction

    // A word ends its packet when its chain bit is clear, or when it is the eighth.
    for (genvar i = 0; i < NW; i++) begin : g_word
        logic       side;
        vfd_cls_t   cls;
        logic [5:0] xsrc;
        assign term[i]  = (5'(i) < cnt_r) &&
                          (!win_r[i][`VFD_CHAIN_BIT] || i == NW - 1);
        assign in_ep[i] = 4'(i) < len;
        assign side     = win_r[i][`VFD_SIDE_BIT];
        // Multiplies are forced onto the multiply unit of their side.
        assign cls      = win_r[i][`VFD_MUL_BIT] ? VFD_CLS_M
                          : vfd_cls_t'(win_r[i][`VFD_CLS_LO +: 2]);
        assign uidx[i]  = {side, cls};
        assign xsrc     = {~side, win_r[i][`VFD_SRC_LO +: 5]};
        assign xrd[i]   = in_ep[i] && win_r[i][`VFD_XP_BIT] && wmask_r[xsrc];
    end

    // An unterminated chain at the end of the window is a partial packet and waits.
    assign complete  = |term;
    assign len       = first_term(term);
    assign hazard    = complete && |xrd;
    assign disp_fire = complete && !hazard;
    assign pop       = disp_fire ? {1'b0, len} : 5'h00;
    assign base      = cnt_r - pop;
    assign load      = FETCH_VALID && pend_r;
    // Fetching only once no whole packet remains keeps the window within 16 words.
    assign FETCH_REQ = !complete && !pend_r;
    assign cnt_nxt   = base + (load ? 5'h08 : 5'h00);

    for (genvar j = 0; j < WIN; j++) begin : g_win
        vfd_cnt_t idx_s;
        vfd_cnt_t off;
        assign idx_s = 5'(j) + pop;
        assign off   = 5'(j) - base;
        assign win_nxt[j] = (idx_s < cnt_r) ? win_r[idx_s[3:0]]
                          : (load && 5'(j) >= base && off < 5'h08)
                          ? FETCH_DATA[32 * off[2:0] +: 32]
                          : 32'h00000000;
    end

    always_comb begin
        wmask_nxt = 64'h0000000000000000;
        for (int i = 0; i < NW; i++) begin
            if (disp_fire && in_ep[i]) begin
                wmask_nxt[{win_r[i][`VFD_SIDE_BIT], win_r[i][`VFD_DST_LO +: 5]}] = 1'b1;
            end
        end
    end

    // Every unit of the packet is loaded in the same cycle.
    always_comb begin
        for (int u = 0; u < NW; u++) begin
            unit_v_nxt[u] = 1'b0;
            unit_i_nxt[u] = 32'h00000000;
            for (int i = 0; i < NW; i++) begin
                if (disp_fire && in_ep[i] && uidx[i] == 3'(u)) begin
                    unit_v_nxt[u] = 1'b1;
                    unit_i_nxt[u] = win_r[i];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_r   <= 5'h00;
            pend_r  <= 1'b0;
            pc_r    <= RESET_ADDR;
            wmask_r <= 64'h0000000000000000;
        end else begin
            cnt_r   <= cnt_nxt;
            pend_r  <= FETCH_REQ || (pend_r && !FETCH_VALID);
            pc_r    <= FETCH_REQ ? pc_r + `VFD_FP_BYTES : pc_r;
            wmask_r <= wmask_nxt;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int j = 0; j < WIN; j++) begin
                win_r[j] <= 32'h00000000;
            end
        end else begin
            for (int j = 0; j < WIN; j++) begin
                win_r[j] <= win_nxt[j];
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            UNIT_VALID <= 8'h00;
            EP_VALID   <= 1'b0;
            EP_SIZE    <= 4'h0;
            DISP_STALL <= 1'b0;
            for (int u = 0; u < NW; u++) begin
                unit_i_r[u] <= 32'h00000000;
            end
        end else begin
            UNIT_VALID <= unit_v_nxt;
            EP_VALID   <= disp_fire;
            EP_SIZE    <= disp_fire ? len : 4'h0;
            DISP_STALL <= hazard;
            for (int u = 0; u < NW; u++) begin
                unit_i_r[u] <= unit_i_nxt[u];
            end
        end
    end

    for (genvar u = 0; u < NW; u++) begin : g_out
        assign UNIT_INSTR[32 * u +: 32] = unit_i_r[u];
    end
    assign FETCH_ADDR = pc_r;

    logic non_m_mul;
    always_comb begin
        non_m_mul = 1'b0;
        for (int u = 0; u < NW; u++) begin
            if (UNIT_VALID[u] && unit_i_r[u][`VFD_MUL_BIT] && u[1:0] != 2'h2) begin
                non_m_mul = 1'b1;
            end
        end
    end

    a_fetch_whole: assert property (@(posedge CLK) disable iff (!ARST_N)
        FETCH_REQ |=> FETCH_ADDR == $past(FETCH_ADDR) + 32'h00000020)
        else $error("Fetch address did not advance by one packet.");

    a_chain_pull: assert property (@(posedge CLK) disable iff (!ARST_N)
        disp_fire && cnt_r > 5'h01 && win_r[0][0] |=> EP_SIZE >= 4'h2)
        else $error("Chained word was left out of its packet.");

    a_chain_break: assert property (@(posedge CLK) disable iff (!ARST_N)
        disp_fire && !win_r[0][0] |=> EP_VALID && EP_SIZE == 4'h1)
        else $error("Clear chain bit did not close the packet.");

    a_size_bound: assert property (@(posedge CLK) disable iff (!ARST_N)
        EP_VALID |-> EP_SIZE >= 4'h1 && EP_SIZE <= 4'h8)
        else $error("Execute packet size out of range.");

    a_units_same: assert property (@(posedge CLK) disable iff (!ARST_N)
        EP_VALID |-> $countones(UNIT_VALID) <= EP_SIZE && UNIT_VALID != 8'h00)
        else $error("Units of a packet not driven together.");

    a_mul_route: assert property (@(posedge CLK) disable iff (!ARST_N)
        !non_m_mul)
        else $error("Multiply issued to a non-multiply unit.");

    a_fetch_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
        FETCH_REQ |-> !complete && !pend_r)
        else $error("Fetch requested while packets remain.");

    a_back_back: assert property (@(posedge CLK) disable iff (!ARST_N)
        complete && !hazard |=> EP_VALID)
        else $error("Ready packet was not dispatched.");

    a_xpath_stall: assert property (@(posedge CLK) disable iff (!ARST_N)
        hazard |=> DISP_STALL && !EP_VALID ##1 !DISP_STALL)
        else $error("Cross-path stall not exactly one cycle.");

    a_partial_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
        cnt_r != 5'h00 && !complete |=> !EP_VALID)
        else $error("Partial packet dispatched before completion.");

    // Checker views of the window, partly built on the dispatch decode they watch (in_ep, len, uidx).
    logic [7:0] chain_open;
    logic [7:0] inner_ok;
    logic [7:0] mul_ok;
    logic       last_chain;
    logic [1:0] held_r;
    logic [1:0] held_nxt;

    for (genvar i = 0; i < NW; i++) begin : g_chk
        assign chain_open[i] = (5'(i) >= cnt_r) || win_r[i][`VFD_CHAIN_BIT];
        assign inner_ok[i]   = !in_ep[i] || 4'(i) == len - 4'h1 || win_r[i][`VFD_CHAIN_BIT];
        assign mul_ok[i]     = !in_ep[i] || !win_r[i][`VFD_MUL_BIT] || uidx[i][1:0] == 2'h2;
    end
    assign last_chain = win_r[len - 4'h1][`VFD_CHAIN_BIT];
    // A ready packet that waits more than one cycle would cost a dispatch slot for good.
    // The count saturates so that a stuck dispatcher keeps the check firing.
    assign held_nxt   = (complete && !disp_fire) ? held_r + {1'b0, held_r != 2'h3} : 2'h0;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            held_r <= 2'h0;
        end else begin
            held_r <= held_nxt;
        end
    end

    a_req_pulse: assert property (@(posedge CLK) disable iff (!ARST_N)
        FETCH_REQ |=> !FETCH_REQ)
        else $error("Fetch request stood for more than one cycle.");

    a_addr_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
        !FETCH_REQ |=> $stable(FETCH_ADDR))
        else $error("Fetch address moved without a request.");

    a_load_eight: assert property (@(posedge CLK) disable iff (!ARST_N)
        load |=> cnt_r == $past(cnt_r) + 5'h08)
        else $error("Fetch packet did not add eight words.");

    a_win_bound: assert property (@(posedge CLK) disable iff (!ARST_N)
        cnt_r <= 5'h10)
        else $error("Instruction window overflowed.");

    a_pend_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
        pend_r |-> !disp_fire)
        else $error("Packet dispatched while a fetch was outstanding.");

    a_fetch_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
        FETCH_REQ |-> cnt_r < 5'h08 && &chain_open)
        else $error("Fetch requested with a closed packet in the window.");

    a_last_closed: assert property (@(posedge CLK) disable iff (!ARST_N)
        disp_fire |-> len == 4'h8 || !last_chain)
        else $error("Packet ended on an open chain word.");

    a_inner_chain: assert property (@(posedge CLK) disable iff (!ARST_N)
        disp_fire |-> &inner_ok)
        else $error("Packet holds a word after a closed chain.");

    a_mul_class: assert property (@(posedge CLK) disable iff (!ARST_N)
        disp_fire |-> &mul_ok)
        else $error("Multiply decoded to a non-multiply class.");

    a_pop_len: assert property (@(posedge CLK) disable iff (!ARST_N)
        disp_fire |=> cnt_r == $past(cnt_r) - {1'b0, $past(len)})
        else $error("Window did not drop exactly one packet.");

    a_ready_wait: assert property (@(posedge CLK) disable iff (!ARST_N)
        held_r <= 2'h1)
        else $error("Ready packet waited more than one cycle.");

    a_idle_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
        !EP_VALID |-> EP_SIZE == 4'h0 && UNIT_VALID == 8'h00)
        else $error("Units driven with no packet dispatched.");

    a_stall_gap: assert property (@(posedge CLK) disable iff (!ARST_N)
        DISP_STALL |-> !EP_VALID)
        else $error("Packet dispatched during a stall cycle.");

    a_stall_once: assert property (@(posedge CLK) disable iff (!ARST_N)
        DISP_STALL |=> !DISP_STALL)
        else $error("Stall lasted more than one cycle.");

    a_hazard_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
        hazard |=> wmask_r == 64'h0000000000000000)
        else $error("Write history survived a stall cycle.");

    // Idle units read as zero so that no unit ever sees a stale opcode.
    for (genvar u = 0; u < NW; u++) begin : g_idle
        a_idle_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
            !UNIT_VALID[u] |-> UNIT_INSTR[32 * u +: 32] == 32'h00000000)
            else $error("Idle unit shows an instruction.");
    end
endmodule

//--- rtl/vfd_params.svh
// Constants of the fetch and dispatch stage.
`ifndef VFD_PARAMS_SVH
`define VFD_PARAMS_SVH
`define VFD_WORDS      8
`define VFD_WIN        16
`define VFD_FP_BYTES   32'h00000020
`define VFD_RESET_ADDR 32'h00000000
`define VFD_CHAIN_BIT  0
`define VFD_SIDE_BIT   1
`define VFD_CLS_LO     2
`define VFD_MUL_BIT    4
`define VFD_XP_BIT     5
`define VFD_SRC_LO     6
`define VFD_DST_LO     11
`endif

//--- rtl/vfd_pkg.sv
// Types shared by the fetch and dispatch stage.
package vfd_pkg;
    typedef logic [31:0] vfd_word_t;
    typedef logic [3:0]  vfd_len_t;
    typedef logic [4:0]  vfd_cnt_t;
    typedef enum logic [1:0] {
        VFD_CLS_L = 2'h0,
        VFD_CLS_S = 2'h1,
        VFD_CLS_M = 2'h2,
        VFD_CLS_D = 2'h3
    } vfd_cls_t;
endpackage

//--- testbench/tb_top.sv
// Testbench for the fetch and dispatch stage.
`timescale 1ns/1ns
module tb_top;
    import vfd_pkg::*;
    logic           clk = 1'b0;
    logic           arst_n = 1'b0;
    logic           f_req, f_val, ep_val, stall;
    logic [31:0]    f_addr;
    logic [255:0]   f_data, u_instr;
    logic [7:0]     u_val;
    logic [3:0]     ep_size;
    logic [1279:0]  image;
    vfd_word_t      pw [0:39];
    logic [284:0]   eq [$];
    logic [63:0]    fq [$];
    logic [15:0]    cyc = '0;
    logic           stl = 1'b0;
    logic [31:0]    wd = '0;
    int             err_total = 0;
    int             n_tests = 0;
    always #2 clk = ~clk;
    vfd_fetch_dispatch i_dut (.CLK(clk), .ARST_N(arst_n), .FETCH_REQ(f_req), .FETCH_ADDR(f_addr),
        .FETCH_VALID(f_val), .FETCH_DATA(f_data), .UNIT_VALID(u_val), .UNIT_INSTR(u_instr),
        .EP_VALID(ep_val), .EP_SIZE(ep_size), .DISP_STALL(stall));
    vfd_prog_mem i_mem (.CLK(clk), .ARST_N(arst_n), .FETCH_REQ(f_req), .FETCH_ADDR(f_addr),
        .IMAGE(image), .FETCH_VALID(f_val), .FETCH_DATA(f_data));
    always @(posedge clk) begin
        cyc <= cyc + 16'h1;
        if (stall === 1'b1) stl <= 1'b1;
        if (ep_val === 1'b1) begin
            eq.push_back({cyc, stl, ep_size, u_val, u_instr});
            stl <= 1'b0;
            wd <= wd + {28'h0, ep_size};
        end
        if (f_req === 1'b1 && arst_n === 1'b1) begin
            fq.push_back({f_addr, wd + ((ep_val === 1'b1) ? {28'h0, ep_size} : 32'h0)});
        end
    end
    function automatic logic [2:0] unit_of(input vfd_word_t w);
        return {w[1], w[4] ? 2'h2 : w[3:2]};
    endfunction
    function automatic vfd_word_t mk(input logic ch, input logic [1:0] cls, input int i);
        return {16'h0, 5'h0, 5'h0, 2'h0, cls, i[2], ch};
    endfunction
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [255:0] exp, input logic [255:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic chk_ep(input int base, input int n, input logic st, output logic [15:0] ts);
        logic [284:0] e;
        logic [7:0]   uv;
        logic [255:0] ui;
        uv = '0;
        ui = '0;
        for (int k = 0; k < n; k++) begin
            uv[unit_of(pw[base+k])] = 1'b1;
            ui[unit_of(pw[base+k])*32 +: 32] = pw[base+k];
        end
        for (int t = 0; t < 80 && eq.size() == 0; t++) @(negedge clk);
        if (eq.size() == 0) begin
            cmp("ep_valid", 256'h1, 256'h0);
            end_of_test();
        end
        e = eq.pop_front();
        ts = e[284:269];
        cmp("ep_size", {252'h0, n[3:0]}, {252'h0, e[267:264]});
        cmp("unit_valid", {248'h0, uv}, {248'h0, e[263:256]});
        cmp("unit_instr", ui, e[255:0]);
        cmp("stall_before", {255'h0, st}, {255'h0, e[268]});
    endtask
    task automatic t_singles;
        logic [15:0] t0, t1;
        chk_ep(0, 1, 1'b0, t0);
        for (int i = 1; i < 8; i++) begin
            chk_ep(i, 1, 1'b0, t1);
            cmp("single_gap", 256'h1, {240'h0, t1 - t0});
            t0 = t1;
        end
        $display("test singles done");
    endtask
    task automatic t_full_and_span;
        logic [15:0] ts;
        chk_ep(8, 8, 1'b0, ts);
        chk_ep(16, 3, 1'b0, ts);
        chk_ep(19, 8, 1'b0, ts);
        for (int i = 27; i < 32; i++) chk_ep(i, 1, 1'b0, ts);
        $display("test full and span done");
    endtask
    task automatic t_hazard;
        logic [15:0] t0, t1;
        chk_ep(32, 1, 1'b0, t0);
        chk_ep(33, 1, 1'b1, t1);
        cmp("stall_gap", 256'h2, {240'h0, t1 - t0});
        chk_ep(34, 1, 1'b0, t1);
        $display("test hazard done");
    endtask
    task automatic t_fetch;
        logic [31:0] exp_w [0:5] = '{32'h0, 32'h8, 32'h10, 32'h13, 32'h20, 32'h28};
        for (int t = 0; t < 200 && fq.size() < 6; t++) @(negedge clk);
        if (fq.size() < 6) cmp("fetch_count", 256'h6, 256'(fq.size()));
        for (int k = 0; k < 6 && k < fq.size(); k++) begin
            cmp("fetch_addr", 256'(32*k), {224'h0, fq[k][63:32]});
            cmp("words_before_fetch", {224'h0, exp_w[k]}, {224'h0, fq[k][31:0]});
        end
        $display("test fetch order done");
    endtask
    initial begin
        for (int i = 0; i < 40; i++) begin
            pw[i] = (i < 32) ? mk((i > 7 && i < 27) && i != 15 && i != 18 && i != 26, i[1:0], i) : '0;
        end
        pw[32] = 32'h00001800;
        pw[33] = 32'h000000E6;
        pw[34] = 32'h00000012;
        for (int i = 0; i < 40; i++) image[32*i +: 32] = pw[i];
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_singles();
        t_full_and_span();
        t_hazard();
        t_fetch();
        end_of_test();
    end
endmodule

//--- testbench/vfd_prog_mem.sv
// Program memory model that answers each fetch request after a prompt or a slow delay.
`timescale 1ns/1ns
module vfd_prog_mem (
    input  wire logic          CLK,
    input  wire logic          ARST_N,
    input  wire logic          FETCH_REQ,
    input  wire logic [31:0]   FETCH_ADDR,
    input  wire logic [1279:0] IMAGE,
    output logic               FETCH_VALID = 1'b0,
    output logic [255:0]       FETCH_DATA = '0
);
    logic [31:0] addr_r;
    logic [2:0]  wait_r;
    logic        busy_r;
    logic        slow_r;
    // Between answers the data lines invert every cycle, so stale data is never reusable.
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            busy_r <= 1'b0;
            slow_r <= 1'b0;
            FETCH_VALID <= 1'b0;
        end else begin
            FETCH_VALID <= 1'b0;
            FETCH_DATA <= ~FETCH_DATA;
            if (FETCH_REQ && !busy_r) begin
                busy_r <= 1'b1;
                addr_r <= FETCH_ADDR;
                wait_r <= slow_r ? 3'h3 : 3'h0;
                slow_r <= ~slow_r;
            end else if (busy_r && wait_r != 3'h0) begin
                wait_r <= wait_r - 3'h1;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                FETCH_VALID <= 1'b1;
                FETCH_DATA <= (addr_r < 32'hA0) ? IMAGE[addr_r*8 +: 256] : '0;
            end
        end
    end
endmodule
